// ===== logic/citd_cfg.svh
// Timing, mapping and opcode constants of the instruction timing decoder.
`ifndef CITD_CFG_SVH
`define CITD_CFG_SVH
`define CITD_CLK_OPCODE_BYTE  4'h2
`define CITD_CLK_READ_BYTE    4'h2
`define CITD_CLK_WRITE_BYTE   4'h3
`define CITD_CLK_ADDR_CALC    4'h1
`define CITD_CLK_MUL          8'h0C
`define CITD_MUL_OPCODE_BYTES 4'h1
`define CITD_PREFIX_BYTES     4'h1
`define CITD_XPC_BASE_NIB     4'hE
`define CITD_XPC_TOP_NIB      4'hF
`define CITD_STACK_DEF_LO     4'hD
`define CITD_STACK_DEF_HI     4'hD
`define CITD_DATA_DEF_LO      4'h4
`define CITD_XPC_RESET        8'h00
`define CITD_STACK_RESET      8'h00
`define CITD_DATA_RESET       8'h00
`define CITD_OP_IOI           8'hD3
`define CITD_OP_IOE           8'hDB
`define CITD_OP_IDX_IX        8'hDD
`define CITD_OP_IDX_IY        8'hFD
`define CITD_OP_ALTD          8'h76
`define CITD_OP_EX_SP_HL      8'hED
`define CITD_OP_MUL           8'hF7
`endif

// ===== logic/citd_pkg.sv
// Types shared by the instruction timing decoder files.
package citd_pkg;
   typedef enum logic [2:0]
   {
      CITD_SP_MEM = 3'b001,
      CITD_SP_INT = 3'b010,
      CITD_SP_EXT = 3'b100
   } citd_space_t;
   typedef enum logic [3:0]
   {
      CITD_TGT_GEN  = 4'b0001,
      CITD_TGT_IDX  = 4'b0010,
      CITD_TGT_PC   = 4'b0100,
      CITD_TGT_DENY = 4'b1000
   } citd_target_t;
   typedef enum logic [3:0]
   {
      CITD_XF_NONE  = 4'b0001,
      CITD_XF_LJP   = 4'b0010,
      CITD_XF_LCALL = 4'b0100,
      CITD_XF_LRET  = 4'b1000
   } citd_xfer_t;
endpackage

// ===== logic/citd_map_if.sv
// Carrier between the decoder and the address mapper.
`timescale 1ns/10ps
interface citd_map_if;
   logic [15:0] logical_addr;
   logic        long_pointer_transfer;
   logic [19:0] long_addr;
   logic [7:0]  extended_code_page;
   logic [7:0]  stack_window_base;
   logic [7:0]  data_base;
   logic [3:0]  stack_lo;
   logic [3:0]  stack_hi;
   logic [3:0]  data_lo;
   logic        stack_enable;
   logic [19:0] phys_addr;
   modport decoder (output logical_addr, output long_pointer_transfer,
                    output long_addr, output extended_code_page,
                    output stack_window_base, output data_base,
                    output stack_lo, output stack_hi, output data_lo,
                    output stack_enable, input phys_addr);
   modport mapper  (input logical_addr, input long_pointer_transfer,
                    input long_addr, input extended_code_page,
                    input stack_window_base, input data_base,
                    input stack_lo, input stack_hi, input data_lo,
                    input stack_enable, output phys_addr);
endinterface

// ===== logic/citd_mapper.sv
// Logical to physical address mapper with root, data, stack and code zones.
`timescale 1ns/10ps
`include "citd_cfg.svh"
module citd_mapper
(
   citd_map_if.mapper m    // Mapping request and result.
);
   logic [3:0] nib;
   logic [7:0] seg;
   logic [7:0] sum;

   // Zone select: code page zone is always the top 8K window.
   always_comb
   begin
      nib = m.logical_addr[15:12];
      if (nib >= `CITD_XPC_BASE_NIB)
         seg = m.extended_code_page;
      else if (m.stack_enable && nib >= m.stack_lo &&
               nib <= m.stack_hi)
         seg = m.stack_window_base;
      else if (nib >= m.data_lo)
         seg = m.data_base;
      else
         seg = 8'h00;
      sum = seg + {4'h0, nib};
   end

   // Long pointer transfers skip the mapping entirely.
   assign m.phys_addr = m.long_pointer_transfer ? m.long_addr
                                              : {sum, m.logical_addr[11:0]};
endmodule

// ===== logic/citd_core.sv
// Instruction timing decoder and address space selection for the core.
// What this block does
// - Each opcode byte and each data byte read costs two clocks.
// - Each data byte written costs three clocks.
// - Computed or index register addressing adds one clock.
// - Multiply is signed 16x16, one opcode byte, twelve clocks.
// - Immediate load to any register except PC, AF pair, IP, F.
// - Immediate load to the program counter acts as a jump.
// - Immediate byte load four clocks, word load six clocks.
// - Index or alternate immediate loads add two clocks for prefix.
// - I/O prefixes steer memory accesses to internal or external I/O.
// - Legacy opcodes keep encodings, except stack top exchange with HL.
// - Long call, return and jump reach a one megabyte code space.
// - Long pointer transfers use the full 20-bit physical address.
// - Writing the stack window base remaps the stack window at once.
// - Stack window normally 4K, may be larger or removed.
// - Extended code page window occupies 8K of 64K logical space.
// - Segment value adds to top four logical bits, giving 20 bits.
`timescale 1ns/10ps
`include "citd_cfg.svh"
module citd_core
(
   input  wire logic                  clock,          // 20 MHz clock.
   input  wire logic                  reset_n,        // Async reset, low.
   input  wire logic                  instr_valid,    // Instruction pulse.
   input  wire logic [7:0]            first_byte,     // First opcode byte.
   input  wire logic [3:0]            opcode_bytes,   // Bytes after prefix.
   input  wire logic [3:0]            read_bytes,     // Data bytes read.
   input  wire logic [3:0]            write_bytes,    // Data bytes written.
   input  wire logic                  addr_computed,  // Index or computed.
   input  wire logic                  is_mul,         // Multiply op.
   input  wire logic                  is_imm_load,    // Immediate load.
   input  wire logic                  imm_word,       // Word immediate.
   input  wire citd_pkg::citd_target_t imm_target,    // Load destination.
   input  wire citd_pkg::citd_xfer_t   xfer,          // Long transfer kind.
   input  wire logic [15:0]           operand_a,      // Multiply input.
   input  wire logic [15:0]           operand_b,      // Multiply input.
   input  wire logic [15:0]           imm_value,      // Immediate or target.
   input  wire logic [7:0]            imm_page,       // Long target page.
   input  wire logic [15:0]           logical_addr,   // Access address.
   input  wire logic                  long_ptr,       // Long pointer op.
   input  wire logic [19:0]           long_addr,      // Long pointer addr.
   input  wire logic                  stack_base_we,  // Stack base write.
   input  wire logic [7:0]            stack_base_in,  // New stack base.
   input  wire logic [3:0]            stack_lo_in,    // Stack zone low nib.
   input  wire logic [3:0]            stack_hi_in,    // Stack zone high nib.
   input  wire logic                  stack_en_in,    // Stack zone present.
   input  wire logic                  data_base_we,   // Data base write.
   input  wire logic [7:0]            data_base_in,   // New data base.
   output logic [7:0]                 cycles_q,       // Clock cost.
   output citd_pkg::citd_space_t      space_q,        // Access space.
   output logic                       jump_q,         // PC load as jump.
   output logic                       load_ok_q,      // Load permitted.
   output logic                       legacy_diff_q,  // Re-encoded opcode.
   output logic [31:0]                product_q,      // Signed product.
   output logic [15:0]                pc_q,           // Program counter.
   output logic [7:0]                 code_page_q,    // Code page register.
   output logic [7:0]                 stack_base_q,   // Stack window base.
   output logic [19:0]                phys_addr_q     // Physical address.
);
   citd_map_if map ();
   logic [7:0] data_base_q;
   logic [3:0] stack_lo_q;
   logic [3:0] stack_hi_q;
   logic       stack_en_q;
   logic [7:0] cycles_d;
   logic [3:0] pfx;

   // Prefix byte decode for the timing; space selection compares first_byte itself.
   function automatic logic is_io_prefix(input logic [7:0] b);
      is_io_prefix = (b == `CITD_OP_IOI) || (b == `CITD_OP_IOE);
   endfunction
   function automatic logic is_reg_prefix(input logic [7:0] b);
      is_reg_prefix = (b == `CITD_OP_IDX_IX) || (b == `CITD_OP_IDX_IY) ||
                      (b == `CITD_OP_ALTD);
   endfunction

   // Cost accumulation; counts are small so 8 bits never overflow.
   always_comb
   begin
      pfx = (is_io_prefix(first_byte) || is_reg_prefix(first_byte)) ?
            `CITD_PREFIX_BYTES : 4'h0;
      if (is_mul)
         cycles_d = `CITD_CLK_MUL;
      else if (is_imm_load)
         // Operand bytes read from the stream, as costed for byte/word.
         cycles_d = 8'(({4'h0, `CITD_MUL_OPCODE_BYTES} +
                        (imm_word ? 8'h2 : 8'h1) + {4'h0, pfx}) *
                       {4'h0, `CITD_CLK_OPCODE_BYTE});
      else
         cycles_d = 8'({4'h0, opcode_bytes + pfx} *
                       {4'h0, `CITD_CLK_OPCODE_BYTE}
                     + {4'h0, read_bytes} * {4'h0, `CITD_CLK_READ_BYTE}
                     + {4'h0, write_bytes} * {4'h0, `CITD_CLK_WRITE_BYTE}
                     + (addr_computed ? {4'h0, `CITD_CLK_ADDR_CALC}
                                      : 8'h00));
   end

   // Per-instruction results are held until the next instruction.
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cycles_q      <= 8'h00;
         space_q       <= citd_pkg::CITD_SP_MEM;
         jump_q        <= 1'b0;
         load_ok_q     <= 1'b0;
         legacy_diff_q <= 1'b0;
         product_q     <= 32'h0000_0000;
         phys_addr_q   <= 20'h0_0000;
      end
      else if (instr_valid)
      begin
         cycles_q <= cycles_d;
         if (first_byte == `CITD_OP_IOI)
            space_q <= citd_pkg::CITD_SP_INT;
         else if (first_byte == `CITD_OP_IOE)
            space_q <= citd_pkg::CITD_SP_EXT;
         else
            space_q <= citd_pkg::CITD_SP_MEM;
         jump_q    <= is_imm_load &&
                      imm_target == citd_pkg::CITD_TGT_PC;
         load_ok_q <= is_imm_load &&
                      (imm_target == citd_pkg::CITD_TGT_GEN ||
                       imm_target == citd_pkg::CITD_TGT_IDX);
         legacy_diff_q <= first_byte == `CITD_OP_EX_SP_HL;
         // The 32-bit target widens both signed factors before the product.
         if (is_mul)
            product_q <= $signed(operand_a) *
                         $signed(operand_b);
         phys_addr_q <= map.phys_addr;
      end
   end

   // Program counter follows jumps and long transfers; code page follows long transfers.
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pc_q        <= 16'h0000;
         code_page_q <= `CITD_XPC_RESET;
      end
      else if (instr_valid)
      begin
         if (is_imm_load && imm_target == citd_pkg::CITD_TGT_PC)
            pc_q <= imm_value;
         unique case (xfer)
            citd_pkg::CITD_XF_NONE:  ;
            citd_pkg::CITD_XF_LJP,
            citd_pkg::CITD_XF_LCALL,
            citd_pkg::CITD_XF_LRET:
            begin
               pc_q        <= imm_value;
               code_page_q <= imm_page;
            end
            default: ;
         endcase
      end
   end

   // Segment registers; a stack write also reaches the mapper in its cycle.
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         stack_base_q <= `CITD_STACK_RESET;
         data_base_q  <= `CITD_DATA_RESET;
         stack_lo_q   <= `CITD_STACK_DEF_LO;
         stack_hi_q   <= `CITD_STACK_DEF_HI;
         stack_en_q   <= 1'b1;
      end
      else
      begin
         if (stack_base_we)
         begin
            stack_base_q <= stack_base_in;
            stack_lo_q   <= stack_lo_in;
            stack_hi_q   <= stack_hi_in;
            stack_en_q   <= stack_en_in;
         end
         if (data_base_we)
            data_base_q <= data_base_in;
      end
   end

   // Mapper inputs; a pending stack write is forwarded to avoid a stale hit.
   assign map.logical_addr          = logical_addr;
   assign map.long_pointer_transfer = long_ptr;
   assign map.long_addr             = long_addr;
   assign map.extended_code_page    = code_page_q;
   assign map.stack_window_base     = stack_base_we ? stack_base_in
                                                    : stack_base_q;
   assign map.data_base             = data_base_q;
   // The whole stack write is forwarded, so base and bounds never mix.
   assign map.stack_lo              = stack_base_we ? stack_lo_in
                                                    : stack_lo_q;
   assign map.stack_hi              = stack_base_we ? stack_hi_in
                                                    : stack_hi_q;
   assign map.data_lo               = `CITD_DATA_DEF_LO;
   assign map.stack_enable          = stack_base_we ? stack_en_in
                                                    : stack_en_q;

   citd_mapper u_mapper
   (
      .m (map.mapper)
   );
endmodule

// ===== tb/citd_core_sva.sv
// Port assertions for the instruction timing decoder.
`timescale 1ns/10ps
`include "citd_cfg.svh"
module citd_core_sva
(
   input wire logic                   clock,         // Clock.
   input wire logic                   reset_n,       // Reset, low.
   input wire logic                   instr_valid,   // Issue.
   input wire logic [7:0]             first_byte,    // First byte.
   input wire logic [3:0]             opcode_bytes,  // Opcode bytes.
   input wire logic [3:0]             read_bytes,    // Read bytes.
   input wire logic [3:0]             write_bytes,   // Write bytes.
   input wire logic                   addr_computed, // Extra clock.
   input wire logic                   is_mul,        // Multiply.
   input wire logic                   is_imm_load,   // Immediate.
   input wire logic                   imm_word,      // Word size.
   input wire citd_pkg::citd_target_t imm_target,    // Destination.
   input wire logic [15:0]            operand_a,     // Factor.
   input wire logic [15:0]            operand_b,     // Factor.
   input wire logic [15:0]            imm_value,     // Target.
   input wire logic [7:0]             cycles_q,      // Cost.
   input wire citd_pkg::citd_space_t  space_q,       // Space.
   input wire logic                   jump_q,        // Jump flag.
   input wire logic                   load_ok_q,     // Load flag.
   input wire logic                   legacy_diff_q, // Re-encoded.
   input wire logic [31:0]            product_q,     // Product.
   input wire logic [15:0]            pc_q           // Counter.
);
   logic                  pfx, is_ed, ok_w;
   logic [7:0]            gen_cost, imm_cost;
   logic [31:0]           prod_w;
   citd_pkg::citd_space_t sp_w;
   // Expected figures, taken from the inputs of the issuing edge.
   assign pfx = first_byte inside {`CITD_OP_IOI, `CITD_OP_IOE,
      `CITD_OP_IDX_IX, `CITD_OP_IDX_IY, `CITD_OP_ALTD};
   assign gen_cost = 8'h02 * ({4'h0, opcode_bytes} + {7'h00, pfx}
      + {4'h0, read_bytes}) + 8'h03 * {4'h0, write_bytes}
      + {7'h00, addr_computed};
   assign imm_cost = (imm_word ? 8'h06 : 8'h04) + (pfx ? 8'h02 : 8'h00);
   assign prod_w = $signed(operand_a) * $signed(operand_b);
   assign is_ed = first_byte == `CITD_OP_EX_SP_HL;
   assign ok_w = imm_target == citd_pkg::CITD_TGT_GEN ||
                 imm_target == citd_pkg::CITD_TGT_IDX;
   assign sp_w = first_byte == `CITD_OP_IOI ? citd_pkg::CITD_SP_INT
      : first_byte == `CITD_OP_IOE ? citd_pkg::CITD_SP_EXT
      : citd_pkg::CITD_SP_MEM;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   sequence s_mul; instr_valid && is_mul; endsequence
   sequence s_imm; instr_valid && is_imm_load && !is_mul; endsequence
   a_mul_cycles: assert property (
      s_mul |=> cycles_q == 8'h0C) else $error("multiply cost wrong");
   a_mul_product: assert property (
      s_mul |=> product_q == $past(prod_w)) else $error("product wrong");
   a_imm_cycles: assert property (
      s_imm |=> cycles_q == $past(imm_cost))
      else $error("immediate load cost wrong");
   a_gen_cycles: assert property (
      instr_valid && !is_mul && !is_imm_load
      |=> cycles_q == $past(gen_cost)) else $error("cost wrong");
   a_space_sel: assert property (
      instr_valid |=> space_q == $past(sp_w)) else $error("space wrong");
   a_legacy_enc: assert property (
      instr_valid |=> legacy_diff_q == $past(is_ed))
      else $error("re-encoded flag wrong");
   a_pc_jump: assert property (
      s_imm and imm_target == citd_pkg::CITD_TGT_PC
      |=> jump_q && pc_q == $past(imm_value)) else $error("jump wrong");
   a_load_deny: assert property (
      s_imm |=> load_ok_q == $past(ok_w))
      else $error("load permission wrong");
endmodule
bind citd_core citd_core_sva citd_core_sva_i (.clock, .reset_n,
   .instr_valid, .first_byte, .opcode_bytes, .read_bytes, .write_bytes,
   .addr_computed, .is_mul, .is_imm_load, .imm_word, .imm_target,
   .operand_a, .operand_b, .imm_value, .cycles_q, .space_q, .jump_q,
   .load_ok_q, .legacy_diff_q, .product_q, .pc_q);

// ===== tb/citd_bus_model.sv
// Far-side model of memory and the two I/O spaces, counting accesses.
`timescale 1ns/10ps
module citd_bus_model
(
   input wire logic                  clock,    // System clock.
   input wire logic                  reset_n,  // Async reset, low.
   input wire logic                  access,   // Access strobe.
   input wire citd_pkg::citd_space_t space,    // Decoded space.
   output logic [15:0]               mem_hits, // Memory accesses.
   output logic [15:0]               int_hits, // Internal I/O hits.
   output logic [15:0]               ext_hits  // External I/O hits.
);
   // Each space is a separate target, so a stray I/O access shows here.
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         {mem_hits, int_hits, ext_hits} <= 48'h0;
      else if (access && space == citd_pkg::CITD_SP_MEM)
         mem_hits <= mem_hits + 16'h0001;
      else if (access && space == citd_pkg::CITD_SP_INT)
         int_hits <= int_hits + 16'h0001;
      else if (access && space == citd_pkg::CITD_SP_EXT)
         ext_hits <= ext_hits + 16'h0001;
   end
endmodule

// ===== tb/citd_core_tb_top.sv
// Random self-checking bench with a reference model of the decoder.
`timescale 1ns/10ps
`include "citd_cfg.svh"
module citd_core_tb_top;
   logic        clock = 0, reset_n = 0, iv = 0, ac = 0, mul = 0, acc = 0;
   logic        imm = 0, wd = 0, lp = 0, swe = 0, sen = 0, dwe = 0;
   logic        m_en = 1, pf, jmp, lok, leg, e_mul = 0;
   logic        e_jmp = 0, e_lok = 0, e_leg = 0;
   logic [2:0]  k;
   logic [3:0]  ob = 0, rb = 0, wb = 0, slo = 0, shi = 0, nb;
   logic [3:0]  m_lo = 4'hD, m_hi = 4'hD;
   logic [7:0]  fb = 0, pg = 0, sbi = 0, dbi = 0, cyc, cp, sb, sg;
   logic [7:0]  m_cp = 0, m_sb = 0, m_db = 0;
   logic [15:0] opa = 0, opb = 0, val = 0, la = 0, pc, m_pc = 0, mh, ih, eh;
   logic [19:0] lad = 0, pa, e_pa = 0;
   logic [31:0] prod, e_prod = 0, seed = 32'hE869, r;
   citd_pkg::citd_space_t  sp, e_sp = citd_pkg::CITD_SP_MEM;
   citd_pkg::citd_target_t tg = citd_pkg::CITD_TGT_GEN;
   citd_pkg::citd_xfer_t   xf = citd_pkg::CITD_XF_NONE;
   int          fail_count = 0, n_compared = 0, e_cyc = 0, e_h[3];
   logic [7:0]  fbs[8] = '{`CITD_OP_IOI, `CITD_OP_IOE, `CITD_OP_IDX_IX,
      `CITD_OP_IDX_IY, `CITD_OP_ALTD, `CITD_OP_EX_SP_HL, `CITD_OP_MUL, 8'h00};
   citd_core citd_core_i
   (
      .clock(clock), .reset_n(reset_n), .instr_valid(iv), .first_byte(fb),
      .opcode_bytes(ob), .read_bytes(rb), .write_bytes(wb),
      .addr_computed(ac), .is_mul(mul), .is_imm_load(imm), .imm_word(wd),
      .imm_target(tg), .xfer(xf), .operand_a(opa), .operand_b(opb),
      .imm_value(val), .imm_page(pg), .logical_addr(la), .long_ptr(lp),
      .long_addr(lad), .stack_base_we(swe), .stack_base_in(sbi),
      .stack_lo_in(slo), .stack_hi_in(shi), .stack_en_in(sen),
      .data_base_we(dwe), .data_base_in(dbi), .cycles_q(cyc), .space_q(sp),
      .jump_q(jmp), .load_ok_q(lok), .legacy_diff_q(leg), .product_q(prod),
      .pc_q(pc), .code_page_q(cp), .stack_base_q(sb), .phys_addr_q(pa)
   );
   citd_bus_model citd_bus_model_i (.clock(clock), .reset_n(reset_n),
      .access(acc), .space(sp), .mem_hits(mh), .int_hits(ih), .ext_hits(eh));
   // Clock and the access strobe that follows each issued instruction.
   always #25 clock = ~clock;
   always @(posedge clock) acc <= iv;
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask
   // Drive one random cycle and advance the reference model with it.
   task automatic step();
      r = rnd();
      {iv, mul, imm} = {r[1:0] != 2'b00, r[3:2] == 2'b00, r[3:2] == 2'b01};
      tg = citd_pkg::citd_target_t'(4'h1 << r[9:8]);
      xf = citd_pkg::citd_xfer_t'(r[3] ? 4'h1 << r[11:10] : 4'h1);
      k = r[6:4];
      if (imm)
         k = {tg == citd_pkg::CITD_TGT_IDX ? 2'b01 : 2'b11, k[0]};
      {pf, fb, wd} = {k < 3'h5, fbs[k], r[7]};
      {ob, rb, wb} = {2'b00, r[13:12] + 2'b01, 2'b00, r[15:14], 2'b00, r[17:16]};
      {ac, lp, swe, sen, {slo, shi}} = {r[19:18], r[22:20] == 3'b000, r[31:23]};
      dwe = !iv && r[24];
      r = rnd();
      {opa, opb} = r;
      r = rnd();
      {la, sbi, dbi} = r;
      if (xf != citd_pkg::CITD_XF_NONE)
         la[15] = 1'b0;
      r = rnd();
      {val, pg, lad} = {r[23:0], r[31:24], r[11:0]};
      if (swe)
         {m_sb, m_lo, m_hi, m_en} = {sbi, slo, shi, sen};
      if (dwe)
         m_db = dbi;
      if (!iv)
         return;
      nb = la[15:12];
      e_cyc = mul ? 12 : imm ? (wd ? 6 : 4) + 2 * pf
         : 2 * (ob + pf + rb) + 3 * wb + ac;
      e_sp = k == 0 ? citd_pkg::CITD_SP_INT : k == 1 ? citd_pkg::CITD_SP_EXT
         : citd_pkg::CITD_SP_MEM;
      e_h[k == 0 ? 1 : k == 1 ? 2 : 0]++;
      {e_leg, e_mul} = {k == 3'h5, mul};
      if (mul)
         e_prod = $signed(opa) * $signed(opb);
      // Only general and index targets take an immediate; PC is a jump.
      e_jmp = imm && tg == citd_pkg::CITD_TGT_PC;
      e_lok = imm && (tg == citd_pkg::CITD_TGT_GEN ||
                      tg == citd_pkg::CITD_TGT_IDX);
      if (e_jmp || xf != citd_pkg::CITD_XF_NONE)
         m_pc = val;
      if (xf != citd_pkg::CITD_XF_NONE)
         m_cp = pg;
      sg = nb >= 4'hE ? m_cp : m_en && nb >= m_lo && nb <= m_hi ? m_sb
         : nb >= 4'h4 ? m_db : 8'h00;
      e_pa = lp ? lad : {sg + {4'h0, nb}, la[11:0]};
   endtask
   task automatic check();
      chk("cycles", e_cyc, cyc);
      chk("space", e_sp, sp);
      chk("re-encoded", e_leg, leg);
      chk("pc", m_pc, pc);
      chk("code page", m_cp, cp);
      chk("stack base", m_sb, sb);
      chk("phys", e_pa, pa);
      if (e_mul)
         chk("product", e_prod, prod);
      chk("jump", {e_jmp, e_lok}, {jmp, lok});
   endtask
   task automatic results();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Main sequence: reset, random traffic, then the far-side tallies.
   initial
   begin
      e_h = '{0, 0, 0};
      repeat (20) @(posedge clock);
      #2 reset_n = 1;
      check();
      repeat (800)
      begin
         step();
         @(posedge clock);
         #2 check();
      end
      {iv, swe, dwe} = 3'b000;
      repeat (2) @(posedge clock);
      #2;
      chk("memory hits", e_h[0], mh);
      chk("internal hits", e_h[1], ih);
      chk("external hits", e_h[2], eh);
      results();
   end
   // A hang is cut short well after the 822 cycles the run needs.
   initial
   begin
      repeat (5000) @(posedge clock);
      fail_count++;
      results();
   end
endmodule
